// ---- pll_sel_pkg.sv ----
// Shared constants, types and register layout for the PLL input selector.
package pll_sel_pkg;

    // ====================================================================
    // Sizes
    localparam int NUM_PLL  = 3;
    localparam int NUM_MON  = 4;
    localparam int NUM_SRC  = 6;
    localparam int SLOT_W   = 3;
    localparam int NUM_SLOT = 6;
    localparam int PRIO_W   = NUM_SLOT * SLOT_W;
    localparam int THIRD    = 2;

    // ====================================================================
    // Sources and modes
    typedef enum logic [2:0] {
        SRC_IN0, SRC_IN1, SRC_IN2, SRC_REF, SRC_CMOS_A, SRC_CMOS_B
    } src_t;
    localparam logic [2:0] SLOT_EMPTY    = 3'h7;
    localparam logic [2:0] SRC_LIMIT     = 3'h6;
    localparam logic [2:0] SHARED_LIMIT  = 3'h4;

    typedef enum logic [1:0] {
        MODE_FREERUN, MODE_ACQUIRE, MODE_LOCKED, MODE_HOLDOVER
    } pll_mode_t;

    // ====================================================================
    // Register map, byte addresses
    localparam int          ADDR_W     = 6;
    localparam logic [5:0]  CTRL_OFS   = 6'h00;
    localparam logic [5:0]  PRIO_OFS   = 6'h0c;
    localparam logic [5:0]  CFG_OFS    = 6'h18;
    localparam logic [5:0]  STAT_OFS   = 6'h1c;
    localparam logic [5:0]  MON_OFS    = 6'h20;
    localparam logic [5:0]  WORD_STEP  = 6'h04;

    typedef struct packed {
        src_t manual_sel;
        logic fastlock_en;
        logic ramp_en;
        logic hitless_en;
        logic revertive;
        logic auto_mode;
    } pll_cfg_t;

    typedef struct packed {
        logic [5:0] ramp_rate;
        logic       cmos_b_used;
        logic       cmos_a_used;
        logic       xtal_ext_clk;
    } dev_cfg_t;

    typedef struct packed {
        logic      lock_loss;
        pll_mode_t mode;
        src_t      sel;
    } pll_status_t;

    typedef struct packed {
        src_t      sel;
        pll_mode_t mode;
        logic      hitless_absorb;
        logic      phase_pass;
        logic      ramp_active;
        logic      fastlock_bw;
        logic      lock_loss;
    } pll_out_t;

    localparam pll_cfg_t          CTRL_RST  = 8'h00;
    localparam logic [PRIO_W-1:0] PRIO_RST  = 18'h3f688;
    localparam dev_cfg_t          CFG_RST   = 9'h000;
    localparam logic [5:0]        RAMP_MAX  = 6'h27;

    // ====================================================================
    // Timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int LOL_CLEAR_US  = 10;
    localparam int LOL_CLEAR_CYC = LOL_CLEAR_US * (CLK_HZ / 1_000_000);

endpackage : pll_sel_pkg

// ---- priority_picker.sv ----
// Picks the first eligible source from a per-PLL priority list.
`timescale 1ns/1ps
`default_nettype none
module priority_picker
    import pll_sel_pkg::*;
(
    input  wire logic [PRIO_W-1:0]  prio,
    input  wire logic [NUM_SRC-1:0] eligible,
    output var  logic               found,
    output var  src_t               best
);
    logic [SLOT_W-1:0] slot;

    // Walk from the highest slot downward so slot 0 is the last, winning write.
    always_comb begin
        found = 1'b0;
        best  = SRC_IN0;
        slot  = SLOT_EMPTY;
        for (int i = NUM_SLOT - 1; i >= 0; i--) begin
            slot = prio[i*SLOT_W +: SLOT_W];
            if (slot < SRC_LIMIT && eligible[slot]) begin
                found = 1'b1;
                best  = src_t'(slot);
            end
        end
    end
endmodule : priority_picker
`default_nettype wire

// ---- lock_loss_monitor.sv ----
// Loss-of-lock indicator for one PLL with a set/clear hysteresis timer.
`timescale 1ns/1ps
`default_nettype none
module lock_loss_monitor
    import pll_sel_pkg::*;
#(
    parameter int CLEAR_CYC = LOL_CLEAR_CYC
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic tracking,
    input  wire logic switch_evt,
    input  wire logic set_cond,
    input  wire logic clear_cond,
    output var  logic lock_loss_ff
);
    localparam int CW = $clog2(CLEAR_CYC + 1);
    logic [CW-1:0] clr_cnt_ff;

    // Clearing needs the tight threshold held for the whole timer, so lock
    // indication does not chatter while pull-in finishes.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lock_loss_ff <= 1'b1;
            clr_cnt_ff   <= '0;
        end else if (!tracking || switch_evt || set_cond) begin
            lock_loss_ff <= 1'b1;
            clr_cnt_ff   <= '0;
        end else if (!clear_cond) begin
            clr_cnt_ff   <= '0;
        end else if (clr_cnt_ff == CW'(CLEAR_CYC - 1)) begin
            lock_loss_ff <= 1'b0;
        end else begin
            clr_cnt_ff   <= clr_cnt_ff + 1'b1;
        end
    end
endmodule : lock_loss_monitor
`default_nettype wire

// ---- pll_input_selector.sv ----
// Input selection, qualification and switching control for three PLLs.
`timescale 1ns/1ps
`default_nettype none
module pll_input_selector
    import pll_sel_pkg::*;
#(
    parameter int LOL_CLEAR = LOL_CLEAR_CYC
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Avalon-MM slave.
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output var  logic [31:0]         avs_readdata,
    output var  logic                avs_waitrequest,
    // Monitor results: index 0..2 shared inputs, 3 accuracy reference.
    input  wire logic [NUM_MON-1:0]  signal_loss_flag,
    input  wire logic [NUM_MON-1:0]  frequency_range_fault_flag,
    input  wire logic                crystal_loss_flag,
    // Activity of cmos_only_input_a (bit 0) and cmos_only_input_b (bit 1).
    input  wire logic [1:0]          cmos_loss_flag,
    // Phase detector frequency comparisons per PLL.
    input  wire logic [NUM_PLL-1:0]  lol_set_cond,
    input  wire logic [NUM_PLL-1:0]  lol_clear_cond,
    output var  pll_out_t            pll_ctl [NUM_PLL],
    output var  logic                crystal_ext_clk_mode,
    output var  logic                crystal_load_cap_en,
    output var  logic [5:0]          ramp_rate_code
);

    // ====================================================================
    // Register storage
    pll_cfg_t          ctrl_ff [NUM_PLL];
    logic [PRIO_W-1:0] prio_ff [NUM_PLL];
    dev_cfg_t          cfg_ff;
    pll_status_t       stat_w  [NUM_PLL];
    logic [31:0]       nxt_readdata;
    logic              req;
    logic              fire;

    assign req  = avs_read || avs_write;
    assign fire = req && !avs_waitrequest;

    // ====================================================================
    // Bus handshake
    // One wait state: the request is seen with waitrequest high, the read
    // word is captured, and waitrequest drops for exactly one cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= nxt_readdata;
        end
    end

    // ====================================================================
    // Read decode
    always_comb begin
        nxt_readdata = '0;
        if (avs_address == CFG_OFS) begin
            nxt_readdata = {23'h000000, cfg_ff};
        end else if (avs_address == STAT_OFS) begin
            nxt_readdata = {14'h0000, stat_w[2], stat_w[1], stat_w[0]};
        end else if (avs_address == MON_OFS) begin
            nxt_readdata = {23'h000000, crystal_loss_flag,
                            frequency_range_fault_flag, signal_loss_flag};
        end else begin
            for (int n = 0; n < NUM_PLL; n++) begin
                if (avs_address == CTRL_OFS + ADDR_W'(n) * WORD_STEP) begin
                    nxt_readdata = {24'h000000, ctrl_ff[n]};
                end
                if (avs_address == PRIO_OFS + ADDR_W'(n) * WORD_STEP) begin
                    nxt_readdata = {14'h0000, prio_ff[n]};
                end
            end
        end
    end

    // ====================================================================
    // Register writes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int n = 0; n < NUM_PLL; n++) begin
                ctrl_ff[n] <= CTRL_RST;
                prio_ff[n] <= PRIO_RST;
            end
        end else if (fire && avs_write) begin
            for (int n = 0; n < NUM_PLL; n++) begin
                if (avs_address == CTRL_OFS + ADDR_W'(n) * WORD_STEP) begin
                    ctrl_ff[n] <= pll_cfg_t'(avs_writedata[7:0]);
                end
                if (avs_address == PRIO_OFS + ADDR_W'(n) * WORD_STEP) begin
                    prio_ff[n] <= avs_writedata[PRIO_W-1:0];
                end
            end
        end
    end

    // Rates past the last table entry are clamped to the fastest one.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cfg_ff <= CFG_RST;
        end else if (fire && avs_write && avs_address == CFG_OFS) begin
            cfg_ff <= dev_cfg_t'(avs_writedata[8:0]);
            if (avs_writedata[8:3] > RAMP_MAX) begin
                cfg_ff.ramp_rate <= RAMP_MAX;
            end
        end
    end

    // ====================================================================
    // Device-wide outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            crystal_ext_clk_mode <= 1'b0;
            crystal_load_cap_en  <= 1'b1;
            ramp_rate_code       <= '0;
        end else begin
            crystal_ext_clk_mode <= cfg_ff.xtal_ext_clk;
            crystal_load_cap_en  <= !cfg_ff.xtal_ext_clk;
            ramp_rate_code       <= cfg_ff.ramp_rate;
        end
    end

    // ====================================================================
    // Source qualification shared by all PLLs
    // Gapped-clock tolerance lives in the monitors themselves, so a valid
    // gapped source arrives here with clean flags and stays eligible.
    logic [NUM_SRC-1:0] mon_ok;
    logic               both_cmos;

    assign both_cmos = cfg_ff.cmos_a_used && cfg_ff.cmos_b_used;

    always_comb begin
        mon_ok = '0;
        for (int i = 0; i < NUM_MON; i++) begin
            mon_ok[i] = !signal_loss_flag[i]
                        && !frequency_range_fault_flag[i];
        end
        // The CMOS pins have no loss or range monitor of their own; their
        // activity only feeds holdover when a single one is in use.
        mon_ok[SRC_CMOS_A] = cfg_ff.cmos_a_used
                             && (both_cmos || !cmos_loss_flag[0]);
        mon_ok[SRC_CMOS_B] = cfg_ff.cmos_b_used
                             && (both_cmos || !cmos_loss_flag[1]);
    end

    // ====================================================================
    // Per-PLL selection state machine
    for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll
        logic [NUM_SRC-1:0] avail;
        logic               auto_ok;
        logic               man_legal;
        logic               found;
        src_t               best;
        src_t               target;
        logic               target_ok;
        logic               do_switch;
        src_t               sel_ff;
        pll_mode_t          mode_ff;
        pll_mode_t          nxt_mode;
        logic               history_ff;
        logic               hitless_ff;
        logic               ramp_ff;
        logic               switch_ff;
        logic               lock_loss_flag;

        // Only the third PLL reaches the CMOS-only pins.
        always_comb begin
            avail = mon_ok;
            if (g != THIRD) begin
                avail[SRC_CMOS_A] = 1'b0;
                avail[SRC_CMOS_B] = 1'b0;
            end
        end

        assign auto_ok   = ctrl_ff[g].auto_mode
                           && !(g == THIRD && both_cmos);
        assign man_legal = ctrl_ff[g].manual_sel < SRC_LIMIT
                           && avail[ctrl_ff[g].manual_sel];

        priority_picker u_pick (
            .prio     (prio_ff[g]),
            .eligible (avail),
            .found    (found),
            .best     (best)
        );

        // Non-revertive keeps a still-good current input even when a better
        // one returns, which avoids a second phase hit after a fault clears.
        always_comb begin
            if (!auto_ok) begin
                target    = ctrl_ff[g].manual_sel;
                target_ok = man_legal;
            end else if (!ctrl_ff[g].revertive
                         && mode_ff inside {MODE_ACQUIRE, MODE_LOCKED}
                         && avail[sel_ff]) begin
                target    = sel_ff;
                target_ok = 1'b1;
            end else begin
                target    = best;
                target_ok = found;
            end
        end

        assign do_switch = target_ok && target != sel_ff;

        always_comb begin
            nxt_mode = mode_ff;
            case (mode_ff)
                MODE_FREERUN, MODE_HOLDOVER: begin
                    if (target_ok) begin
                        nxt_mode = MODE_ACQUIRE;
                    end
                end
                MODE_ACQUIRE, MODE_LOCKED: begin
                    if (!target_ok) begin
                        nxt_mode = history_ff ? MODE_HOLDOVER
                                              : MODE_FREERUN;
                    end else if (do_switch) begin
                        nxt_mode = MODE_ACQUIRE;
                    end else if (mode_ff == MODE_ACQUIRE && !lock_loss_flag) begin
                        nxt_mode = MODE_LOCKED;
                    end
                end
                default: nxt_mode = MODE_FREERUN;
            endcase
        end

        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                mode_ff   <= MODE_FREERUN;
                sel_ff    <= SRC_IN0;
                switch_ff <= 1'b0;
            end else begin
                mode_ff   <= nxt_mode;
                switch_ff <= do_switch;
                if (do_switch) begin
                    sel_ff <= target;
                end
            end
        end

        // Averaged frequency history exists once the loop has been locked.
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                history_ff <= 1'b0;
            end else if (mode_ff == MODE_LOCKED) begin
                history_ff <= 1'b1;
            end
        end

        // Absorbing the phase step is only possible between two monitored,
        // frequency-locked inputs, and the CMOS pins are never among them.
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                hitless_ff <= 1'b0;
            end else if (do_switch) begin
                hitless_ff <= ctrl_ff[g].hitless_en
                              && mode_ff == MODE_LOCKED
                              && target < SHARED_LIMIT
                              && sel_ff < SHARED_LIMIT;
            end else if (nxt_mode == MODE_LOCKED) begin
                hitless_ff <= 1'b0;
            end
        end

        // Ramping covers both a fresh switch and leaving holdover.
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                ramp_ff <= 1'b0;
            end else if (nxt_mode == MODE_ACQUIRE && mode_ff != MODE_FREERUN
                         && (do_switch || mode_ff == MODE_HOLDOVER)) begin
                ramp_ff <= ctrl_ff[g].ramp_en;
            end else if (nxt_mode != MODE_ACQUIRE) begin
                ramp_ff <= 1'b0;
            end
        end

        lock_loss_monitor #(
            .CLEAR_CYC (LOL_CLEAR)
        ) u_lol (
            .sys_clk      (sys_clk),
            .sys_rst      (sys_rst),
            .tracking     (mode_ff == MODE_ACQUIRE || mode_ff == MODE_LOCKED),
            .switch_evt   (switch_ff),
            .set_cond     (lol_set_cond[g]),
            .clear_cond   (lol_clear_cond[g]),
            .lock_loss_ff (lock_loss_flag)
        );

        assign stat_w[g] = '{lock_loss: lock_loss_flag, mode: mode_ff, sel: sel_ff};

        // The controls are registered copies so the loop sees one clean
        // update per cycle; output edges stay glitch-free across a switch.
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                pll_ctl[g] <= '{sel: SRC_IN0, mode: MODE_FREERUN,
                                hitless_absorb: 1'b0, phase_pass: 1'b0,
                                ramp_active: 1'b0, fastlock_bw: 1'b0,
                                lock_loss: 1'b1};
            end else begin
                pll_ctl[g].sel            <= sel_ff;
                pll_ctl[g].mode           <= mode_ff;
                pll_ctl[g].hitless_absorb <= hitless_ff;
                pll_ctl[g].phase_pass     <= mode_ff == MODE_ACQUIRE
                                             && !hitless_ff;
                pll_ctl[g].ramp_active    <= ramp_ff;
                pll_ctl[g].fastlock_bw    <= ctrl_ff[g].fastlock_en
                                             && mode_ff == MODE_ACQUIRE;
                pll_ctl[g].lock_loss      <= lock_loss_flag;
            end
        end
    end

endmodule : pll_input_selector
`default_nettype wire

// ---- pll_sel_properties.sv ----
// Concurrent checks on the PLL input selector ports.
`timescale 1ns/1ps
`default_nettype none
module pll_sel_properties
    import pll_sel_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       avs_waitrequest,
    input var  pll_out_t   pll_ctl [NUM_PLL],
    input wire logic       crystal_ext_clk_mode,
    input wire logic       crystal_load_cap_en,
    input wire logic [5:0] ramp_rate_code
);
    // ====================================================================
    // Port relations
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice");
    a_caps_off: assert property (crystal_load_cap_en == !crystal_ext_clk_mode)
        else $error("load caps disagree with clock mode");
    a_ramp_clamp: assert property (ramp_rate_code <= RAMP_MAX)
        else $error("ramp code out of range");
    a_cmos_hitless: assert property (pll_ctl[THIRD].sel inside {SRC_CMOS_A, SRC_CMOS_B} |-> !pll_ctl[THIRD].hitless_absorb)
        else $error("hitless on cmos input");
    a_first_shared: assert property (pll_ctl[0].mode == MODE_LOCKED |-> pll_ctl[0].sel < SHARED_LIMIT)
        else $error("first pll locked to cmos input");
    a_switch_flag: assert property (!$stable(pll_ctl[1].sel) |-> ##[0:2] pll_ctl[1].lock_loss)
        else $error("no lock loss after switch");
    a_pass_phase: assert property (pll_ctl[1].phase_pass |-> pll_ctl[1].mode == MODE_ACQUIRE && !pll_ctl[1].hitless_absorb)
        else $error("phase pass outside acquire");
    a_fast_acq: assert property (pll_ctl[1].fastlock_bw |-> pll_ctl[1].mode == MODE_ACQUIRE)
        else $error("fast bandwidth outside acquire");
    a_hold_flag: assert property ($rose(pll_ctl[0].mode == MODE_HOLDOVER) |-> ##[0:2] pll_ctl[0].lock_loss)
        else $error("holdover without lock loss");
    c_hold: cover property (pll_ctl[0].mode == MODE_HOLDOVER);
    c_alt: cover property (pll_ctl[1].mode == MODE_LOCKED && pll_ctl[1].sel == SRC_IN1);
    c_cmos: cover property (pll_ctl[THIRD].mode == MODE_LOCKED && pll_ctl[THIRD].sel == SRC_CMOS_A);
endmodule : pll_sel_properties
`default_nettype wire

// ---- clk_source_model.sv ----
// Model of the clock sources and monitors feeding the selector.
`timescale 1ns/1ps
`default_nettype none
module clk_source_model
    import pll_sel_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic [3:0]   loss_req,
    input  wire logic [3:0]   fault_req,
    input  wire logic [1:0]   cmos_req,
    input  wire logic         xtal_req,
    input  wire logic [2:0]   lol_req,
    output var  logic [3:0]   signal_loss_flag,
    output var  logic [3:0]   frequency_range_fault_flag,
    output var  logic [1:0]   cmos_loss_flag,
    output var  logic         crystal_loss_flag,
    output var  logic [2:0]   lol_set_cond,
    output var  logic [2:0]   lol_clear_cond
);
    // Both cmos sources come from one oscillator, so only their presence differs.
    always_ff @(posedge sys_clk) begin
        signal_loss_flag <= loss_req;
        frequency_range_fault_flag <= fault_req;
        cmos_loss_flag <= cmos_req;
        crystal_loss_flag <= xtal_req;
    end
    // Sources, gapped ones too, stay in the pull-in range; lock is lost only on request.
    assign lol_set_cond = lol_req;
    assign lol_clear_cond = ~lol_req;
endmodule : clk_source_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the PLL input selector.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pll_sel_pkg::*;
;
    logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, xtal_req, crystal_loss_flag;
    logic crystal_ext_clk_mode, crystal_load_cap_en;
    logic [5:0] avs_address, ramp_rate_code;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] loss_req, fault_req, signal_loss_flag, frequency_range_fault_flag;
    logic [1:0] cmos_req, cmos_loss_flag;
    logic [2:0] lol_set_cond, lol_clear_cond, lol_req;
    pll_out_t pll_ctl [NUM_PLL];
    int n_fail, checked;
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    pll_input_selector #(.LOL_CLEAR(4)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .signal_loss_flag(signal_loss_flag),
        .frequency_range_fault_flag(frequency_range_fault_flag), .crystal_loss_flag(crystal_loss_flag),
        .cmos_loss_flag(cmos_loss_flag), .lol_set_cond(lol_set_cond), .lol_clear_cond(lol_clear_cond),
        .pll_ctl(pll_ctl), .crystal_ext_clk_mode(crystal_ext_clk_mode),
        .crystal_load_cap_en(crystal_load_cap_en), .ramp_rate_code(ramp_rate_code));
    clk_source_model u_src (.sys_clk(sys_clk), .loss_req(loss_req), .fault_req(fault_req), .cmos_req(cmos_req),
        .xtal_req(xtal_req), .signal_loss_flag(signal_loss_flag), .frequency_range_fault_flag(frequency_range_fault_flag),
        .cmos_loss_flag(cmos_loss_flag), .crystal_loss_flag(crystal_loss_flag), .lol_set_cond(lol_set_cond),
        .lol_clear_cond(lol_clear_cond), .lol_req(lol_req));
    // ====================================================================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) chk(32'h1, 32'h0);
    endtask : bus
    task wait_mode(input int p, input pll_mode_t m);
        int n;
        n = 0;
        while (pll_ctl[p].mode !== m && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        chk(32'(pll_ctl[p].mode), 32'(m));
    endtask : wait_mode
    // ====================================================================
    // Scenarios
    task t_regs;
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, PRIO_OFS + WORD_STEP, 32'h0);
        chk(rd, 32'(PRIO_RST));
        bus(1'b0, 6'h24, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, CFG_OFS, 32'h1f9);
        repeat (2) @(posedge sys_clk);
        chk(32'(ramp_rate_code), 32'(RAMP_MAX));
        chk(32'(crystal_load_cap_en), 32'h0);
        chk(32'(crystal_ext_clk_mode), 32'h1);
        bus(1'b1, CFG_OFS, 32'h8);
        $display("t_regs done");
    endtask : t_regs
    task t_auto;
        bus(1'b1, CTRL_OFS + WORD_STEP, 32'h11);
        wait_mode(1, MODE_LOCKED);
        chk(32'(pll_ctl[1].sel), 32'(SRC_IN0));
        lol_req <= 3'h2;
        repeat (3) @(posedge sys_clk);
        chk(32'(pll_ctl[1].lock_loss), 32'h1);
        lol_req <= 3'h0;
        repeat (10) @(posedge sys_clk);
        chk(32'(pll_ctl[1].lock_loss), 32'h0);
        loss_req <= 4'h1;
        wait_mode(1, MODE_ACQUIRE);
        chk(32'(pll_ctl[1].phase_pass), 32'h1);
        chk(32'(pll_ctl[1].fastlock_bw), 32'h1);
        wait_mode(1, MODE_LOCKED);
        chk(32'(pll_ctl[1].sel), 32'(SRC_IN1));
        loss_req <= 4'h0;
        repeat (20) @(posedge sys_clk);
        chk(32'(pll_ctl[1].sel), 32'(SRC_IN1));
        bus(1'b1, CTRL_OFS + WORD_STEP, 32'h1f);
        wait_mode(1, MODE_ACQUIRE);
        chk(32'(pll_ctl[1].hitless_absorb), 32'h1);
        chk(32'(pll_ctl[1].phase_pass), 32'h0);
        chk(32'(pll_ctl[1].ramp_active), 32'h1);
        wait_mode(1, MODE_LOCKED);
        chk(32'(pll_ctl[1].sel), 32'(SRC_IN0));
        fault_req <= 4'hf;
        wait_mode(1, MODE_HOLDOVER);
        fault_req <= 4'h0;
        $display("t_auto done");
    endtask : t_auto
    task t_manual;
        bus(1'b1, CTRL_OFS, 32'h60);
        wait_mode(0, MODE_ACQUIRE);
        wait_mode(0, MODE_LOCKED);
        chk(32'(pll_ctl[0].sel), 32'(SRC_REF));
        loss_req <= 4'h8;
        xtal_req <= 1'b1;
        wait_mode(0, MODE_HOLDOVER);
        bus(1'b0, MON_OFS, 32'h0);
        chk(rd, 32'h108);
        $display("t_manual done");
    endtask : t_manual
    task t_cmos;
        bus(1'b1, CFG_OFS, 32'h2);
        bus(1'b1, 6'h08, 32'h84);
        wait_mode(2, MODE_ACQUIRE);
        chk(32'(pll_ctl[2].hitless_absorb), 32'h0);
        wait_mode(2, MODE_LOCKED);
        chk(32'(pll_ctl[2].sel), 32'(SRC_CMOS_A));
        cmos_req <= 2'h1;
        wait_mode(2, MODE_HOLDOVER);
        cmos_req <= 2'h0;
        wait_mode(2, MODE_LOCKED);
        bus(1'b1, CFG_OFS, 32'h6);
        bus(1'b1, 6'h08, 32'h85);
        cmos_req <= 2'h1;
        repeat (20) @(posedge sys_clk);
        chk(32'(pll_ctl[2].mode), 32'(MODE_LOCKED));
        chk(32'(pll_ctl[2].sel), 32'(SRC_CMOS_A));
        $display("t_cmos done");
    endtask : t_cmos
    task report_and_stop;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        {sys_rst, avs_read, avs_write, xtal_req, avs_address, avs_writedata} = {1'b1, 41'h0};
        {loss_req, fault_req, cmos_req, lol_req, n_fail, checked} = '0;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_auto;
        t_manual;
        t_cmos;
        report_and_stop;
    end
    initial begin
        #(20000 * 50);
        n_fail++;
        report_and_stop;
    end
endmodule : tb_top
bind pll_input_selector pll_sel_properties u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_waitrequest(avs_waitrequest), .pll_ctl(pll_ctl), .crystal_ext_clk_mode(crystal_ext_clk_mode),
    .crystal_load_cap_en(crystal_load_cap_en), .ramp_rate_code(ramp_rate_code));
`default_nettype wire
